// ===== mmsc_pkg.sv
// Constants, register map and types for the monitor mode and status control.
// Assumes one 20 MHz system clock and a synchronous active-high reset.
package mmsc_pkg;

  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_SHIFT     = 8'h04;
  localparam logic [7:0] ADDR_ZOOM      = 8'h08;
  localparam logic [7:0] ADDR_STATUS    = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h14;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_PED_BIT  = 4;
  localparam int ST_PAL_BIT    = 4;
  localparam int ST_VALID_BIT  = 5;
  localparam int ST_LOCAL_BIT  = 6;
  localparam int ST_LIMIT_LSB  = 8;
  localparam int IRQ_N         = 5;
  localparam int IRQ_MODE      = 0;
  localparam int IRQ_STD       = 1;
  localparam int IRQ_FAULT     = 2;
  localparam int IRQ_LOCATE    = 3;
  localparam int IRQ_REFUSED   = 4;

  // ----------------------------------------
  // Video figures
  // ----------------------------------------
  localparam logic [9:0] PIX_SD       = 10'd720;
  localparam logic [9:0] LINES_LB_N   = 10'd360;
  localparam logic [9:0] LINES_LB_P   = 10'd430;
  localparam logic [9:0] LINES_FULL_N = 10'd486;
  localparam logic [9:0] LINES_FULL_P = 10'd576;
  localparam logic [6:0] STEPS_1080   = 7'd60;
  localparam logic [6:0] STEPS_1035   = 7'd68;
  localparam logic [6:0] STEPS_720    = 7'd40;
  localparam int         PIX_PER_STEP = 8;
  localparam logic [6:0] ZOOM_MAX     = 7'd64;
  localparam int         ZOOM_SHIFT   = 6;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ        = 20_000_000;
  localparam int LONG_HALF_MS  = 500;
  localparam int SHORT_HALF_MS = 100;
  localparam int BUSY_HOLD_US  = 100;
  localparam int LONG_HALF_CYC  = CLK_HZ / 1000 * LONG_HALF_MS;
  localparam int SHORT_HALF_CYC = CLK_HZ / 1000 * SHORT_HALF_MS;
  localparam int BUSY_HOLD_CYC  = CLK_HZ / 1_000_000 * BUSY_HOLD_US;
  localparam logic [2:0] LOCATE_HALVES = 3'd6;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    STD_NONE = 2'h0, STD_1080 = 2'h1, STD_1035 = 2'h2, STD_720 = 2'h3
  } mmsc_std_t;
  typedef enum logic [1:0] {
    RATE_NONE = 2'h0, RATE_50 = 2'h1, RATE_5994 = 2'h2, RATE_60 = 2'h3
  } mmsc_rate_t;
  typedef enum logic [3:0] {
    MODE_LBOX = 4'b0001, MODE_AMOR = 4'b0010,
    MODE_FULL = 4'b0100, MODE_ZOOM = 4'b1000
  } mmsc_mode_t;
  typedef enum logic [3:0] {
    FN_IDLE = 4'h0, FN_MODE = 4'h1, FN_SHIFT = 4'h2,
    FN_ZOOM = 4'h3, FN_PED = 4'h4
  } mmsc_func_t;

endpackage

// ===== mmsc_top.sv
// Status lamps, output standard choice and display mode settings.
// Assumes detector inputs and switch pulses are synchronous to i_clock.
`timescale 1ns/1ns
`default_nettype none
module mmsc_top
  import mmsc_pkg::*;
#(
  parameter int LONG_CYC  = LONG_HALF_CYC,
  parameter int SHORT_CYC = SHORT_HALF_CYC
) (
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic [1:0]  i_std_detect,
  input  wire logic [1:0]  i_rate_detect,
  input  wire logic        i_internal_fault,
  input  wire logic        i_config_problem,
  input  wire logic        i_bus_activity,
  input  wire logic        i_locate_cmd,
  input  wire logic        i_init_busy,
  input  wire logic        i_fw_update,
  input  wire logic        i_power_ok,
  input  wire logic        i_local_only,
  input  wire logic [3:0]  i_func_sel,
  input  wire logic        i_paddle_left,
  input  wire logic        i_paddle_right,
  output logic             o_fault_indicator,
  output logic             o_bus_activity_indicator,
  output logic             o_config_busy_indicator,
  output logic             o_power_good_indicator,
  output logic      [2:0]  o_rate_indicator,
  output logic      [2:0]  o_std_indicator,
  output logic      [3:0]  o_mode_indicator,
  output logic             o_output_valid,
  output logic             o_output_pal,
  output logic      [9:0]  o_out_pixels,
  output logic      [9:0]  o_out_lines,
  output logic             o_pedestal_on,
  output logic signed [10:0] o_shift_pixels,
  output logic      [6:0]  o_zoom,
  output logic             o_irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    mmsc_mode_t         mode;
    logic               ped;
    logic signed [7:0]  shift;
    logic [6:0]         zoom;
    logic [IRQ_N-1:0]   irq_stat;
    logic [IRQ_N-1:0]   irq_mask;
    logic [31:0]        rdata;
    logic [31:0]        long_cnt;
    logic [31:0]        short_cnt;
    logic               long_ph;
    logic               short_ph;
    logic               act_seen;
    logic               act_on;
    logic [2:0]         locate_left;
    logic [15:0]        busy_cnt;
    logic [1:0]         std_prev;
    logic               fault_prev;
    logic               fault_led;
    logic               bus_led;
    logic               busy_led;
    logic               pwr_led;
    logic [2:0]         rate_led;
    logic [2:0]         std_led;
    logic               valid;
    logic               pal;
    logic [9:0]         pix;
    logic [9:0]         lines;
    logic               ped_on;
    logic signed [10:0] shift_pix;
  } mmsc_state_t;

  mmsc_state_t state_ff;
  mmsc_state_t nxt_state;

  // ----------------------------------------
  // Decoded input and limits
  // ----------------------------------------
  logic        in_valid;
  logic        in_pal;
  logic [6:0]  base_steps;
  logic [6:0]  shift_limit;
  logic [13:0] zoom_prod;
  logic        remote_ok;
  logic        long_wrap;
  logic        short_wrap;

  always_comb begin
    unique case (i_std_detect)
      STD_1080: in_valid = (i_rate_detect != RATE_NONE);
      STD_1035,
      STD_720:  in_valid = (i_rate_detect == RATE_5994) || (i_rate_detect == RATE_60);
      default:  in_valid = 1'b0;
    endcase
    in_pal = in_valid && (i_std_detect == STD_1080) && (i_rate_detect == RATE_50);
    case (i_std_detect)
      STD_1080: base_steps = STEPS_1080;
      STD_1035: base_steps = STEPS_1035;
      STD_720:  base_steps = STEPS_720;
      default:  base_steps = 7'd0;
    endcase
    zoom_prod = base_steps * state_ff.zoom;
    case (state_ff.mode)
      MODE_FULL: shift_limit = in_valid ? base_steps : 7'd0;
      // Zero at letterbox zoom, full table value at full-screen zoom
      MODE_ZOOM: shift_limit = in_valid ? zoom_prod[12:6] : 7'd0;
      default:   shift_limit = 7'd0;
    endcase
    remote_ok  = !i_local_only;
    long_wrap  = (state_ff.long_cnt >= 32'(LONG_CYC - 1));
    short_wrap = (state_ff.short_cnt >= 32'(SHORT_CYC - 1));
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [IRQ_N-1:0] ev;
    logic             mode_chg;
    logic             ped_req;
    logic             ped_val;
    logic signed [8:0] sh;
    logic [7:0]       zm;
    ev        = '0;
    mode_chg  = 1'b0;
    ped_req   = 1'b0;
    ped_val   = state_ff.ped;
    sh        = 9'(state_ff.shift);
    zm        = {1'b0, state_ff.zoom};
    nxt_state = state_ff;

    // Flash timebases
    nxt_state.long_cnt  = long_wrap ? 32'h0 : state_ff.long_cnt + 32'h1;
    nxt_state.short_cnt = short_wrap ? 32'h0 : state_ff.short_cnt + 32'h1;
    if (long_wrap) begin
      nxt_state.long_ph = !state_ff.long_ph;
    end
    if (short_wrap) begin
      nxt_state.short_ph = !state_ff.short_ph;
    end

    // Traffic is sampled per short period so isolated bursts still flash
    nxt_state.act_seen = state_ff.act_seen | i_bus_activity;
    if (short_wrap && state_ff.short_ph) begin
      nxt_state.act_on   = state_ff.act_seen | i_bus_activity;
      nxt_state.act_seen = 1'b0;
    end
    if (i_locate_cmd) begin
      nxt_state.locate_left = LOCATE_HALVES;
      ev[IRQ_LOCATE] = 1'b1;
    end else if (long_wrap && state_ff.locate_left != 3'd0) begin
      nxt_state.locate_left = state_ff.locate_left - 3'd1;
    end

    // Local paddle steps
    if (i_paddle_left ^ i_paddle_right) begin
      case (i_func_sel)
        FN_MODE: begin
          mode_chg = 1'b1;
          if (i_paddle_right) begin
            nxt_state.mode = mmsc_mode_t'({state_ff.mode[2:0], state_ff.mode[3]});
          end else begin
            nxt_state.mode = mmsc_mode_t'({state_ff.mode[0], state_ff.mode[3:1]});
          end
        end
        FN_SHIFT: begin
          if (state_ff.mode == MODE_FULL || state_ff.mode == MODE_ZOOM) begin
            sh = i_paddle_left ? sh - 9'sd1 : sh + 9'sd1;
          end
        end
        FN_ZOOM: begin
          if (state_ff.mode == MODE_ZOOM) begin
            if (i_paddle_left && state_ff.zoom < ZOOM_MAX) begin
              zm = zm + 8'd1;
            end else if (i_paddle_right && state_ff.zoom != 7'd0) begin
              zm = zm - 8'd1;
            end
          end
        end
        FN_PED: begin
          ped_req = 1'b1;
          ped_val = i_paddle_left;
        end
        default: begin
        end
      endcase
    end

    // Register port writes
    if (i_wr) begin
      case (i_addr)
        ADDR_CTRL: begin
          if (remote_ok) begin
            if (i_wdata[3:0] == MODE_LBOX || i_wdata[3:0] == MODE_AMOR ||
                i_wdata[3:0] == MODE_FULL || i_wdata[3:0] == MODE_ZOOM) begin
              mode_chg       = (i_wdata[3:0] != state_ff.mode);
              nxt_state.mode = mmsc_mode_t'(i_wdata[3:0]);
            end
            ped_req = 1'b1;
            ped_val = i_wdata[CTRL_PED_BIT];
          end else begin
            ev[IRQ_REFUSED] = 1'b1;
          end
        end
        ADDR_SHIFT: begin
          if (remote_ok) begin
            sh = 9'($signed(i_wdata[7:0]));
          end else begin
            ev[IRQ_REFUSED] = 1'b1;
          end
        end
        ADDR_ZOOM: begin
          if (remote_ok) begin
            zm = (i_wdata[6:0] > ZOOM_MAX) ? {1'b0, ZOOM_MAX} : {1'b0, i_wdata[6:0]};
          end else begin
            ev[IRQ_REFUSED] = 1'b1;
          end
        end
        ADDR_IRQ_STAT: nxt_state.irq_stat = state_ff.irq_stat & ~i_wdata[IRQ_N-1:0];
        ADDR_IRQ_MASK: nxt_state.irq_mask = i_wdata[IRQ_N-1:0];
        default: begin
        end
      endcase
    end

    // Pedestal only changes on a 525-line output
    if (ped_req && in_valid && !in_pal) begin
      nxt_state.ped = ped_val;
    end
    nxt_state.zoom = zm[6:0];
    // Keep shift inside the current window, even when the limit shrinks
    if (sh > $signed({2'b00, shift_limit})) begin
      sh = $signed({2'b00, shift_limit});
    end else if (sh < -$signed({2'b00, shift_limit})) begin
      sh = -$signed({2'b00, shift_limit});
    end
    nxt_state.shift = sh[7:0];

    // Busy lamp hold after a mode change
    if (mode_chg) begin
      nxt_state.busy_cnt = 16'(BUSY_HOLD_CYC);
      ev[IRQ_MODE] = 1'b1;
    end else if (state_ff.busy_cnt != 16'h0) begin
      nxt_state.busy_cnt = state_ff.busy_cnt - 16'h1;
    end

    // Events; a set in the same cycle as a clear wins
    nxt_state.std_prev   = i_std_detect;
    nxt_state.fault_prev = i_internal_fault;
    ev[IRQ_STD]   = (i_std_detect != state_ff.std_prev);
    ev[IRQ_FAULT] = i_internal_fault && !state_ff.fault_prev;
    nxt_state.irq_stat = nxt_state.irq_stat | ev;

    // Read data, valid the cycle after the strobe only
    nxt_state.rdata = 32'h0;
    if (i_rd) begin
      case (i_addr)
        ADDR_CTRL:     nxt_state.rdata = {27'h0, state_ff.ped, state_ff.mode};
        ADDR_SHIFT:    nxt_state.rdata = {{24{state_ff.shift[7]}}, state_ff.shift};
        ADDR_ZOOM:     nxt_state.rdata = {25'h0, state_ff.zoom};
        ADDR_STATUS:   nxt_state.rdata = {17'h0, shift_limit, 1'b0, i_local_only,
                                          in_valid, in_pal, i_rate_detect, i_std_detect};
        ADDR_IRQ_STAT: nxt_state.rdata = {{(32-IRQ_N){1'b0}}, state_ff.irq_stat};
        ADDR_IRQ_MASK: nxt_state.rdata = {{(32-IRQ_N){1'b0}}, state_ff.irq_mask};
        default:       nxt_state.rdata = 32'h0;
      endcase
    end

    // ----------------------------------------
    // Lamps
    // ----------------------------------------
    if (i_internal_fault) begin
      nxt_state.fault_led = 1'b1;
    end else begin
      nxt_state.fault_led = i_config_problem && state_ff.long_ph;
    end
    if (state_ff.locate_left != 3'd0) begin
      nxt_state.bus_led = state_ff.long_ph;
    end else begin
      nxt_state.bus_led = state_ff.act_on && state_ff.short_ph;
    end
    nxt_state.busy_led = i_init_busy || i_fw_update ||
                         (state_ff.busy_cnt != 16'h0) || mode_chg;
    nxt_state.pwr_led  = i_power_ok;
    nxt_state.rate_led = 3'b000;
    nxt_state.std_led  = 3'b000;
    if (in_valid) begin
      nxt_state.rate_led = 3'b001 << (i_rate_detect - 2'd1);
      nxt_state.std_led  = 3'b001 << (i_std_detect - 2'd1);
    end

    // ----------------------------------------
    // Output format
    // ----------------------------------------
    nxt_state.valid = in_valid;
    nxt_state.pal   = in_pal;
    nxt_state.pix   = in_valid ? PIX_SD : 10'd0;
    case (nxt_state.mode)
      MODE_LBOX: nxt_state.lines = in_pal ? LINES_LB_P : LINES_LB_N;
      MODE_AMOR: nxt_state.lines = in_pal ? LINES_FULL_P : LINES_FULL_N;
      default:   nxt_state.lines = in_pal ? LINES_FULL_P : LINES_FULL_N;
    endcase
    if (!in_valid) begin
      nxt_state.lines = 10'd0;
    end
    nxt_state.ped_on    = state_ff.ped && in_valid && !in_pal;
    nxt_state.shift_pix = 11'(sh * 9'sd8);
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_ff          <= '0;
      state_ff.mode     <= MODE_LBOX;
      state_ff.busy_cnt <= 16'(BUSY_HOLD_CYC);
      state_ff.busy_led <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_rdata                  = state_ff.rdata;
  assign o_fault_indicator        = state_ff.fault_led;
  assign o_bus_activity_indicator = state_ff.bus_led;
  assign o_config_busy_indicator  = state_ff.busy_led;
  assign o_power_good_indicator   = state_ff.pwr_led;
  assign o_rate_indicator         = state_ff.rate_led;
  assign o_std_indicator          = state_ff.std_led;
  assign o_mode_indicator         = state_ff.mode;
  assign o_output_valid           = state_ff.valid;
  assign o_output_pal             = state_ff.pal;
  assign o_out_pixels             = state_ff.pix;
  assign o_out_lines              = state_ff.lines;
  assign o_pedestal_on            = state_ff.ped_on;
  assign o_shift_pixels           = state_ff.shift_pix;
  assign o_zoom                   = state_ff.zoom;
  assign o_irq                    = |(state_ff.irq_stat & state_ff.irq_mask);

endmodule
`default_nettype wire

// ===== mmsc_panel.sv
// Operator model: rotary function switch and paddle switch.
// Assumes the bench calls press() from its main sequence only.
`timescale 1ns/1ns
`default_nettype none
module mmsc_panel (
  input  wire logic       i_clock,
  output logic      [3:0] o_func_sel,
  output logic            o_paddle_left,
  output logic            o_paddle_right
);
  initial begin
    o_func_sel     = 4'h0;
    o_paddle_left  = 1'b0;
    o_paddle_right = 1'b0;
  end
  // Rotary settles a cycle before the paddle, as a hand would
  task automatic press(input logic [3:0] f, input logic r);
    @(posedge i_clock);
    o_func_sel <= f;
    @(posedge i_clock);
    o_paddle_left  <= !r;
    o_paddle_right <= r;
    @(posedge i_clock);
    o_paddle_left  <= 1'b0;
    o_paddle_right <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== mmsc_checker.sv
// Port-level checks for the monitor mode and status control.
// Assumes binding into mmsc_top; detector inputs are levels.
`timescale 1ns/1ns
`default_nettype none
module mmsc_checker
  import mmsc_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_reset,
  input wire logic [7:0]  i_addr,
  input wire logic        i_wr,
  input wire logic [1:0]  i_std_detect,
  input wire logic [1:0]  i_rate_detect,
  input wire logic        i_internal_fault,
  input wire logic        i_config_problem,
  input wire logic        i_locate_cmd,
  input wire logic        i_local_only,
  input wire logic        i_paddle_left,
  input wire logic        i_paddle_right,
  input wire logic        o_fault_indicator,
  input wire logic        o_bus_activity_indicator,
  input wire logic        o_config_busy_indicator,
  input wire logic [2:0]  o_rate_indicator,
  input wire logic [2:0]  o_std_indicator,
  input wire logic [3:0]  o_mode_indicator,
  input wire logic        o_output_valid,
  input wire logic        o_output_pal,
  input wire logic [9:0]  o_out_pixels,
  input wire logic [9:0]  o_out_lines,
  input wire logic signed [10:0] o_shift_pixels,
  input wire logic [6:0]  o_zoom
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic [7:0]  vid_q;
  logic [10:0] lim8;
  logic [10:0] mag;
  always_ff @(posedge i_clock) begin
    vid_q <= (i_std_detect != 2'h0 && i_rate_detect != 2'h0
              && (i_std_detect == 2'h1 || i_rate_detect != 2'h1))
             ? {1'b1, i_std_detect == 2'h1 && i_rate_detect == 2'h1,
                3'h1 << (i_rate_detect - 2'h1), 3'h1 << (i_std_detect - 2'h1)} : 8'h0;
  end
  assign lim8 = o_std_indicator[0] ? {1'b0, STEPS_1080, 3'h0} :
                o_std_indicator[1] ? {1'b0, STEPS_1035, 3'h0} :
                o_std_indicator[2] ? {1'b0, STEPS_720, 3'h0} : 11'h0;
  assign mag  = o_shift_pixels[10] ? 11'(-o_shift_pixels) : o_shift_pixels;
  sequence s_held(logic [3:0] m);
    (o_mode_indicator == m && o_output_valid && $stable(o_output_pal)) [*3];
  endsequence
  sequence s_std_held;
    $stable(o_std_indicator) [*3];
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_std_lamp: assert property (
    !$past(i_reset) |-> o_std_indicator == vid_q[2:0]) else $error("Standard lamp wrong");
  a_rate_lamp: assert property (
    !$past(i_reset) |-> o_rate_indicator == vid_q[5:3]) else $error("Rate lamp wrong");
  a_pal_select: assert property (
    !$past(i_reset) |-> {o_output_valid, o_output_pal} == vid_q[7:6])
    else $error("Output standard wrong");
  a_fault_lamp: assert property (
    !$past(i_reset) && ($past(i_internal_fault) || !$past(i_config_problem))
    |-> o_fault_indicator == $past(i_internal_fault)) else $error("Fault lamp wrong");
  a_busy_change: assert property (
    $changed(o_mode_indicator) |-> o_config_busy_indicator [*8])
    else $error("Busy lamp not held on mode change");
  a_mode_onehot: assert property (
    $onehot(o_mode_indicator)) else $error("Mode lamps not one-hot");
  a_lbox_lines: assert property (
    s_held(MODE_LBOX) |-> o_out_pixels == PIX_SD
    && o_out_lines == (o_output_pal ? LINES_LB_P : LINES_LB_N)) else $error("Letterbox size");
  a_amor_lines: assert property (
    s_held(MODE_AMOR) |-> o_out_pixels == PIX_SD
    && o_out_lines == (o_output_pal ? LINES_FULL_P : LINES_FULL_N)) else $error("Amorphous size");
  a_shift_bound: assert property (
    s_held(MODE_FULL) and s_std_held |-> o_shift_pixels[2:0] == 3'h0 && mag <= lim8)
    else $error("Shift out of range");
  a_zoom_min: assert property (
    (o_mode_indicator == MODE_ZOOM && o_zoom == 7'h0) [*3] |-> o_shift_pixels == 11'sh0)
    else $error("Shift at minimum zoom");
  a_remote_lock: assert property (
    i_local_only && i_wr && i_addr == ADDR_CTRL && !i_paddle_left && !i_paddle_right
    |=> $stable(o_mode_indicator)) else $error("Remote write not locked out");
  a_locate_flash: assert property (
    i_locate_cmd |-> ##[1:40] o_bus_activity_indicator) else $error("No locate flash");
endmodule
bind mmsc_top mmsc_checker u_chk (.*);
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for mmsc_top with short flash periods.
// Assumes mmsc_checker is bound and mmsc_panel models the switches.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import mmsc_pkg::*;
  logic        i_clock, i_reset, i_wr, i_rd, i_internal_fault, i_config_problem;
  logic        i_bus_activity, i_locate_cmd, i_init_busy, i_fw_update, i_power_ok;
  logic        i_local_only, i_paddle_left, i_paddle_right, o_irq, o_pedestal_on;
  logic        o_fault_indicator, o_bus_activity_indicator, o_config_busy_indicator;
  logic        o_power_good_indicator, o_output_valid, o_output_pal;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata, o_rdata, d;
  logic [1:0]  i_std_detect, i_rate_detect;
  logic [3:0]  i_func_sel, o_mode_indicator, m;
  logic [2:0]  o_rate_indicator, o_std_indicator;
  logic [9:0]  o_out_pixels, o_out_lines;
  logic [6:0]  o_zoom;
  logic [7:0]  st;
  logic signed [10:0] o_shift_pixels;
  int          n_fail, samples_checked, seed, k, cnt;
  mmsc_top #(.LONG_CYC(8), .SHORT_CYC(4)) dut (.*);
  mmsc_panel u_panel (.i_clock(i_clock), .o_func_sel(i_func_sel),
                      .o_paddle_left(i_paddle_left), .o_paddle_right(i_paddle_right));
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] exp_vid(logic [1:0] s, logic [1:0] r);
    if (s == 2'h0 || r == 2'h0 || (s != 2'h1 && r == 2'h1)) return 32'h0;
    return {24'h0, 1'b1, s == 2'h1 && r == 2'h1, 3'h1 << (r - 2'h1), 3'h1 << (s - 2'h1)};
  endfunction
  function automatic int lim(logic [1:0] s);
    return s == 2'h1 ? STEPS_1080 : s == 2'h2 ? STEPS_1035 : STEPS_720;
  endfunction
  function automatic logic [31:0] exp_shift(logic [7:0] v8, int l);
    int v;
    v = $signed(v8);
    if (v > l) v = l;
    if (v < -l) v = -l;
    return {21'h0, 11'(v * PIX_PER_STEP)};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge i_clock);
    @(negedge i_clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clock);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_clock);
    i_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clock);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clock);
    i_rd   <= 1'b0;
    @(negedge i_clock);
    v = o_rdata;
  endtask
  task automatic vid(input logic [1:0] s, input logic [1:0] r);
    @(posedge i_clock);
    i_std_detect  <= s;
    i_rate_detect <= r;
    settle();
    chk({o_output_valid, o_output_pal, o_rate_indicator, o_std_indicator},
        exp_vid(s, r));
  endtask
  task automatic results();
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clock);
    n_fail++;
    results();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {i_wr, i_rd, i_internal_fault, i_config_problem, i_bus_activity, i_locate_cmd} = 6'h0;
    {i_init_busy, i_fw_update, i_local_only, i_addr, i_wdata} = 43'h0;
    {i_std_detect, i_rate_detect} = 4'h0;
    i_power_ok = 1'b1;
    n_fail = 0;
    samples_checked = 0;
    seed = 25;
    i_reset = 1'b1;
    repeat (4) @(posedge i_clock);
    i_reset <= 1'b0;
    @(negedge i_clock);
    chk({o_config_busy_indicator, o_mode_indicator}, {1'b1, MODE_LBOX});
    for (k = 0; k < 36; k++) begin
      m = (k < 16) ? k[3:0] : 4'($random(seed));
      vid(m[3:2], m[1:0]);
    end
    for (k = 0; k < 8; k++) begin
      vid(2'h1, k[2] ? 2'h1 : 2'h2);
      m = 4'h1 << k[1:0];
      wr(ADDR_CTRL, {28'h0, m});
      settle();
      chk({o_config_busy_indicator, o_mode_indicator}, {1'b1, m});
      if (k[1:0] < 2) chk({o_out_pixels, o_out_lines}, {PIX_SD, k[0] ? (k[2] ? LINES_FULL_P :
        LINES_FULL_N) : (k[2] ? LINES_LB_P : LINES_LB_N)});
    end
    wr(ADDR_CTRL, 32'h18);
    settle();
    chk(o_pedestal_on, 1'b0);
    vid(2'h1, 2'h2);
    wr(ADDR_CTRL, 32'h11);
    settle();
    chk(o_pedestal_on, 1'b1);
    u_panel.press(4'h4, 1'b1);
    settle();
    chk(o_pedestal_on, 1'b0);
    wr(ADDR_CTRL, 32'h4);
    for (k = 0; k < 12; k++) begin
      vid(2'(k % 3 + 1), 2'h2);
      st = (k < 3) ? 8'h7F : (k < 6) ? 8'h80 : 8'($random(seed));
      wr(ADDR_SHIFT, {24'h0, st});
      settle();
      chk({21'h0, o_shift_pixels}, exp_shift(st, lim(2'(k % 3 + 1))));
    end
    vid(2'h1, 2'h2);
    wr(ADDR_SHIFT, 32'h0);
    u_panel.press(4'h2, 1'b1);
    settle();
    chk({21'h0, o_shift_pixels}, exp_shift(8'h01, STEPS_1080));
    u_panel.press(4'h2, 1'b0);
    u_panel.press(4'h2, 1'b0);
    settle();
    chk({21'h0, o_shift_pixels}, exp_shift(8'hFF, STEPS_1080));
    wr(ADDR_CTRL, 32'h8);
    // Zoom first: at zoom zero the shift is clamped to nothing
    for (k = 64; k > 0; k -= 32) begin
      wr(ADDR_ZOOM, 32'(k));
      wr(ADDR_SHIFT, 32'h7F);
      settle();
      chk({21'h0, o_shift_pixels}, exp_shift(8'h7F, STEPS_1080 * k >> ZOOM_SHIFT));
    end
    u_panel.press(4'h3, 1'b1);
    settle();
    chk({o_zoom, 14'h0, o_shift_pixels}, {7'h1F, 25'h0} | exp_shift(8'h7F, 29));
    wr(ADDR_ZOOM, 32'h0);
    settle();
    chk({21'h0, o_shift_pixels}, 32'h0);
    u_panel.press(4'h1, 1'b1);
    settle();
    chk(o_mode_indicator, MODE_LBOX);
    u_panel.press(4'h1, 1'b0);
    settle();
    chk(o_mode_indicator, MODE_ZOOM);
    @(posedge i_clock);
    i_local_only <= 1'b1;
    wr(ADDR_IRQ_STAT, 32'hFF);
    wr(ADDR_IRQ_MASK, 32'h0);
    wr(ADDR_CTRL, 32'h2);
    settle();
    chk({o_irq, o_mode_indicator}, {1'b0, MODE_ZOOM});
    wr(ADDR_IRQ_MASK, 32'h10);
    settle();
    chk(o_irq, 1'b1);
    rd(ADDR_STATUS, d);
    chk(d[6], 1'b1);
    wr(ADDR_IRQ_STAT, 32'h10);
    rd(8'h20, d);
    chk(d, 32'h0);
    chk(o_irq, 1'b0);
    i_local_only <= 1'b0;
    i_internal_fault <= 1'b1;
    settle();
    chk(o_fault_indicator, 1'b1);
    i_internal_fault <= 1'b0;
    i_config_problem <= 1'b1;
    cnt = 0;
    repeat (40) @(negedge i_clock) cnt += o_fault_indicator;
    chk(cnt > 5 && cnt < 35, 1'b1);
    i_config_problem <= 1'b0;
    settle();
    chk(o_fault_indicator, 1'b0);
    i_locate_cmd <= 1'b1;
    @(posedge i_clock);
    i_locate_cmd <= 1'b0;
    cnt = 0;
    repeat (40) @(negedge i_clock) cnt += o_bus_activity_indicator;
    chk(cnt > 5 && cnt < 40, 1'b1);
    repeat (100) @(negedge i_clock);
    chk(o_bus_activity_indicator, 1'b0);
    repeat (2100) @(negedge i_clock);
    chk(o_config_busy_indicator, 1'b0);
    // One traffic pulse gives one short flash only
    i_bus_activity <= 1'b1;
    @(posedge i_clock);
    i_bus_activity <= 1'b0;
    cnt = 0;
    repeat (40) @(negedge i_clock) cnt += o_bus_activity_indicator;
    chk(cnt > 0 && cnt < 8, 1'b1);
    {i_init_busy, i_power_ok} <= 2'b10;
    settle();
    chk({o_config_busy_indicator, o_power_good_indicator}, 2'b10);
    {i_init_busy, i_fw_update} <= 2'b01;
    settle();
    chk(o_config_busy_indicator, 1'b1);
    i_fw_update <= 1'b0;
    settle();
    chk(o_config_busy_indicator, 1'b0);
    results();
  end
endmodule
`default_nettype wire
